// [dac_atten_map.vh]
// Register indices, field positions, reset values and ramp timing of the control bank
`ifndef DAC_ATTEN_MAP_VH
`define DAC_ATTEN_MAP_VH

// Control word layout
`define WORD_RW_BIT        15
`define WORD_IDX_MSB       14
`define WORD_IDX_LSB       8
`define WORD_DATA_MSB      7

// Register indices
`define IDX_ATTEN_CH1      7'h01
`define IDX_ATTEN_CH2      7'h02
`define IDX_ATTEN_CH3      7'h03
`define IDX_ATTEN_CH4      7'h04
`define IDX_ATTEN_CH5      7'h05
`define IDX_ATTEN_CH6      7'h06
`define IDX_MUTE_LO        7'h07
`define IDX_DISABLE_LO     7'h08
`define IDX_FILT_CLK       7'h09
`define IDX_ATTEN_CH7      7'h10
`define IDX_ATTEN_CH8      7'h11
`define IDX_MUTE_HI        7'h12
`define IDX_DISABLE_HI     7'h13

// Field positions inside the filter / clock-out register
`define ROLLOFF_BIT        5
`define CLKDIV_BIT         4
`define CLKOUT_OFF_BIT     3
`define FORMAT_MSB         2

// Reset values and levels
`define ATTEN_RESET        8'hff
`define CTRL_RESET         8'h00
`define ATTEN_MUTE_LEVEL   8'h80
`define READ_ZERO          8'h00

// Ramp timing
`define CLK_FREQ_HZ        100000000
`define SAMPLE_RATE_HZ     48000
`define CYCLES_PER_SAMPLE  (`CLK_FREQ_HZ / `SAMPLE_RATE_HZ)
`define SAMPLES_PER_STEP   8

`endif

// [atten_ramp.v]
// One channel attenuator that walks its applied level toward the goal
`include "dac_atten_map.vh"

module atten_ramp (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       step_en,
  input  wire [7:0] target_level,
  input  wire       mute,
  output reg  [7:0] level_r
);

  reg  [7:0] goal;
  reg  [7:0] level_nxt;

  // Goal: infinite attenuation when muted or field in the mute range
  always @* begin
    if (mute || (target_level <= `ATTEN_MUTE_LEVEL)) begin
      goal = `ATTEN_MUTE_LEVEL;
    end else begin
      goal = target_level;
    end
  end

  // One 0.5 dB step per enable, always from the level now applied
  always @* begin
    level_nxt = level_r;
    if (step_en) begin
      if (level_r < goal) begin
        level_nxt = level_r + 8'h01;
      end else if (level_r > goal) begin
        level_nxt = level_r - 8'h01;
      end
    end
  end

  // Applied level register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_r <= `ATTEN_RESET;
    end else begin
      level_r <= level_nxt;
    end
  end

endmodule // atten_ramp

// [dac_attenuation_mute_ctrl.v]
// Eight-channel attenuation, soft-mute and output control register bank
//
// Behaviour
// - Bit 15 zero writes, one reads
// - Bits 14 to 8 carry register index
// - Eight attenuation fields, reset to 255
// - Values 129..255 give 0.5 dB steps
// - Values 0..128 mean infinite attenuation
// - Level moves one step per eight samples
// - Soft-mute bit zero: normal operation
// - Soft-mute one ramps down to mute
// - Soft-mute cleared ramps back to setting
// - Disable bit routes output to common mode
// - Rolloff bit: zero sharp, one slow
// - Clock-out divider bit: one halves rate
`include "dac_atten_map.vh"

module dac_attenuation_mute_ctrl #(
  parameter CHANNELS          = 8,
  parameter CYCLES_PER_SAMPLE = `CYCLES_PER_SAMPLE,
  parameter SAMPLES_PER_STEP  = `SAMPLES_PER_STEP
) (
  input  wire                  CLK,
  input  wire                  RST_N,
  input  wire                  CTRL_STB,
  input  wire [15:0]           CTRL_WORD,
  output reg  [15:0]           RD_WORD,
  output reg                   RD_VALID,
  output wire [CHANNELS*8-1:0] ATTEN_APPLIED,
  output reg  [CHANNELS-1:0]   CH_SILENT,
  output reg  [CHANNELS-1:0]   OUT_TO_COMMON_MODE,
  output reg                   ROLLOFF_SLOW,
  output reg                   CLKOUT_HALF,
  output reg                   CLKOUT_DISABLE,
  output reg  [2:0]            AUDIO_FORMAT
);

  // Stored register contents
  reg  [7:0]            atten_r [0:CHANNELS-1];
  reg  [7:0]            mute_lo_r;
  reg  [7:0]            mute_hi_r;
  reg  [7:0]            disable_lo_r;
  reg  [7:0]            disable_hi_r;
  reg  [7:0]            filt_clk_r;

  // Sample-rate and ramp-step dividers
  reg  [15:0]           sample_cnt_r;
  reg  [3:0]            step_cnt_r;
  reg                   step_en_r;

  // Decoded command fields
  wire                  is_read;
  wire [6:0]            idx;
  wire [7:0]            wdata;
  wire                  wr_stb;
  wire                  rd_stb;
  reg  [7:0]            rd_data;

  wire [CHANNELS-1:0]   mute_bits;
  wire [CHANNELS-1:0]   disable_bits;
  wire [7:0]            applied [0:CHANNELS-1];

  // One loop index per process, so no variable has two drivers
  integer               i;
  integer               j;
  integer               k;

  // Index of the attenuation register that serves a channel
  function [6:0] atten_index;
    input integer ch;
    begin
      case (ch)
        0:       atten_index = `IDX_ATTEN_CH1;
        1:       atten_index = `IDX_ATTEN_CH2;
        2:       atten_index = `IDX_ATTEN_CH3;
        3:       atten_index = `IDX_ATTEN_CH4;
        4:       atten_index = `IDX_ATTEN_CH5;
        5:       atten_index = `IDX_ATTEN_CH6;
        6:       atten_index = `IDX_ATTEN_CH7;
        default: atten_index = `IDX_ATTEN_CH8;
      endcase
    end
  endfunction

  // Split the 16-bit control word
  assign is_read = CTRL_WORD[`WORD_RW_BIT];
  assign idx     = CTRL_WORD[`WORD_IDX_MSB:`WORD_IDX_LSB];
  assign wdata   = CTRL_WORD[`WORD_DATA_MSB:0];
  assign wr_stb  = CTRL_STB && !is_read;
  assign rd_stb  = CTRL_STB && is_read;

  // Per-channel bits gathered from the low and high register pairs
  assign mute_bits    = {mute_hi_r[1:0], mute_lo_r[5:0]};
  assign disable_bits = {disable_hi_r[1:0], disable_lo_r[5:0]};

  // Attenuation fields
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        atten_r[i] <= `ATTEN_RESET;
      end
    end else if (wr_stb) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        if (idx == atten_index(i)) begin
          atten_r[i] <= wdata;
        end
      end
    end
  end

  // Mute, disable and filter / clock-out registers, reserved bits kept as written
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mute_lo_r    <= `CTRL_RESET;
      mute_hi_r    <= `CTRL_RESET;
      disable_lo_r <= `CTRL_RESET;
      disable_hi_r <= `CTRL_RESET;
      filt_clk_r   <= `CTRL_RESET;
    end else if (wr_stb) begin
      case (idx)
        `IDX_MUTE_LO:    mute_lo_r    <= wdata;
        `IDX_MUTE_HI:    mute_hi_r    <= wdata;
        `IDX_DISABLE_LO: disable_lo_r <= wdata;
        `IDX_DISABLE_HI: disable_hi_r <= wdata;
        `IDX_FILT_CLK:   filt_clk_r   <= wdata;
        default: begin
        end
      endcase
    end
  end

  // Sample tick every CYCLES_PER_SAMPLE clocks, step enable every eighth sample
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sample_cnt_r <= 16'h0000;
      step_cnt_r   <= 4'h0;
      step_en_r    <= 1'b0;
    end else begin
      step_en_r <= 1'b0;
      if (sample_cnt_r == CYCLES_PER_SAMPLE[15:0] - 16'h0001) begin
        sample_cnt_r <= 16'h0000;
        if (step_cnt_r == SAMPLES_PER_STEP[3:0] - 4'h1) begin
          step_cnt_r <= 4'h0;
          step_en_r  <= 1'b1;
        end else begin
          step_cnt_r <= step_cnt_r + 4'h1;
        end
      end else begin
        sample_cnt_r <= sample_cnt_r + 16'h0001;
      end
    end
  end

  // One ramping attenuator per channel
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : gen_ch
      atten_ramp u_ramp (
        .clk          (CLK),
        .rst_n        (RST_N),
        .step_en      (step_en_r),
        .target_level (atten_r[g]),
        .mute         (mute_bits[g]),
        .level_r      (applied[g])
      );
      assign ATTEN_APPLIED[g*8 +: 8] = applied[g];
    end
  endgenerate

  // Registered per-channel status and control outputs
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CH_SILENT          <= {CHANNELS{1'b0}};
      OUT_TO_COMMON_MODE <= {CHANNELS{1'b0}};
      ROLLOFF_SLOW       <= 1'b0;
      CLKOUT_HALF        <= 1'b0;
      CLKOUT_DISABLE     <= 1'b0;
      AUDIO_FORMAT       <= 3'h0;
    end else begin
      for (j = 0; j < CHANNELS; j = j + 1) begin
        CH_SILENT[j] <= (applied[j] <= `ATTEN_MUTE_LEVEL);
      end
      OUT_TO_COMMON_MODE <= disable_bits;
      ROLLOFF_SLOW       <= filt_clk_r[`ROLLOFF_BIT];
      CLKOUT_HALF        <= filt_clk_r[`CLKDIV_BIT];
      CLKOUT_DISABLE     <= filt_clk_r[`CLKOUT_OFF_BIT];
      AUDIO_FORMAT       <= filt_clk_r[`FORMAT_MSB:0];
    end
  end

  // Read data select, unmapped indices read as zero
  always @* begin
    rd_data = `READ_ZERO;
    for (k = 0; k < CHANNELS; k = k + 1) begin
      if (idx == atten_index(k)) begin
        rd_data = atten_r[k];
      end
    end
    case (idx)
      `IDX_MUTE_LO:    rd_data = mute_lo_r;
      `IDX_MUTE_HI:    rd_data = mute_hi_r;
      `IDX_DISABLE_LO: rd_data = disable_lo_r;
      `IDX_DISABLE_HI: rd_data = disable_hi_r;
      `IDX_FILT_CLK:   rd_data = filt_clk_r;
      default: begin
      end
    endcase
  end

  // Read answer: echo of the command header plus stored byte, one-cycle valid
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_WORD  <= 16'h0000;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= rd_stb;
      if (rd_stb) begin
        RD_WORD <= {CTRL_WORD[15:8], rd_data};
      end
    end
  end

endmodule // dac_attenuation_mute_ctrl

// [dac_ctrl_props.sv]
// Assertions on the ports of the attenuation and mute control bank
`include "dac_atten_map.vh"
module dac_ctrl_props #(
  parameter CHANNELS          = 8,
  parameter CYCLES_PER_SAMPLE = 4,
  parameter SAMPLES_PER_STEP  = 8
) (
  input wire logic                  CLK,
  input wire logic                  RST_N,
  input wire logic                  CTRL_STB,
  input wire logic [15:0]           CTRL_WORD,
  input wire logic [15:0]           RD_WORD,
  input wire logic                  RD_VALID,
  input wire logic [CHANNELS*8-1:0] ATTEN_APPLIED,
  input wire logic [CHANNELS-1:0]   CH_SILENT,
  input wire logic [CHANNELS-1:0]   OUT_TO_COMMON_MODE,
  input wire logic                  ROLLOFF_SLOW,
  input wire logic                  CLKOUT_HALF
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = CYCLES_PER_SAMPLE * SAMPLES_PER_STEP;
  logic [31:0] gap_r;
  logic        seen_r;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Cycles since the applied levels last moved
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gap_r  <= 32'h0000_0000;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= $changed(ATTEN_APPLIED) ? 32'h0000_0000 : gap_r + 1;
      seen_r <= seen_r | $changed(ATTEN_APPLIED);
    end
  end
  a_read_answer: assert property (CTRL_STB && CTRL_WORD[15] |=>
    RD_VALID && RD_WORD[15:8] == $past(CTRL_WORD[15:8])) else $error("read answer wrong");
  a_valid_cause: assert property (RD_VALID |-> $past(CTRL_STB && CTRL_WORD[15]))
    else $error("answer without read");
  a_rolloff_set: assert property (CTRL_STB && CTRL_WORD[15:8] == 8'h09 |=> ##1
    ROLLOFF_SLOW == $past(CTRL_WORD[5], 2)) else $error("rolloff not taken");
  a_clkdiv_set: assert property (CTRL_STB && CTRL_WORD[15:8] == 8'h09 |=> ##1
    CLKOUT_HALF == $past(CTRL_WORD[4], 2)) else $error("divider not taken");
  a_disable_set: assert property (CTRL_STB && CTRL_WORD[15:8] == 8'h08 |=> ##1
    OUT_TO_COMMON_MODE[5:0] == $past(CTRL_WORD[5:0], 2)) else $error("disable not taken");
  a_step_size: assert property ($changed(ATTEN_APPLIED[7:0]) |->
    ATTEN_APPLIED[7:0] - $past(ATTEN_APPLIED[7:0]) inside {8'h01, 8'hff}) else $error("step size");
  a_step_pace: assert property ($changed(ATTEN_APPLIED) && seen_r |->
    gap_r % STEP == STEP - 1) else $error("step pace");
  a_mute_floor: assert property (ATTEN_APPLIED[7:0] >= 8'h80) else $error("below mute");
  a_silent_flag: assert property (CH_SILENT[0] == ($past(ATTEN_APPLIED[7:0]) <= 8'h80))
    else $error("silent flag");
  c_read: cover property (CTRL_STB && CTRL_WORD[15]);
  c_silent: cover property (CH_SILENT[0]);
  c_common: cover property (OUT_TO_COMMON_MODE[7]);
endmodule // dac_ctrl_props
bind dac_attenuation_mute_ctrl dac_ctrl_props #(.CHANNELS(CHANNELS),
  .CYCLES_PER_SAMPLE(CYCLES_PER_SAMPLE), .SAMPLES_PER_STEP(SAMPLES_PER_STEP)) dac_ctrl_props_i (
  .CLK(CLK), .RST_N(RST_N), .CTRL_STB(CTRL_STB), .CTRL_WORD(CTRL_WORD), .RD_WORD(RD_WORD),
  .RD_VALID(RD_VALID), .ATTEN_APPLIED(ATTEN_APPLIED), .CH_SILENT(CH_SILENT),
  .OUT_TO_COMMON_MODE(OUT_TO_COMMON_MODE), .ROLLOFF_SLOW(ROLLOFF_SLOW), .CLKOUT_HALF(CLKOUT_HALF));

// [ctrl_host.sv]
// Host model that issues control words on the control port
module ctrl_host (
  input  wire logic        clk,
  output logic             stb,
  output logic [15:0]      word,
  input  wire logic [15:0] rdw,
  input  wire logic        rdv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    stb  = 1'b0;
    word = 16'h0000;
  end
  // One word per access; reserved bits are cleared before sending
  task automatic access(input logic rd, input logic [6:0] idx, input logic [7:0] dat,
                        output logic [15:0] got, output logic ok);
    logic [7:0] m;
    m = (idx inside {7'h07, 7'h08, 7'h09}) ? 8'h3f : (idx inside {7'h12, 7'h13}) ? 8'h03 : 8'hff;
    @(posedge clk);
    stb  <= 1'b1;
    word <= {rd, idx, rd ? 8'h00 : dat & m};
    @(posedge clk);
    stb  <= 1'b0;
    word <= ~word; // Released word shows garbage
    #1;
    got = rdw;
    ok  = rdv;
  endtask
endmodule // ctrl_host

// [dac_attenuation_mute_ctrl_test.sv]
// Self-checking bench for the attenuation and mute control bank
module dac_attenuation_mute_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  wire         stb, rdv, roll, half, cdis;
  wire  [2:0]  fmt;
  wire  [15:0] word, rdw;
  wire  [63:0] lvl;
  wire  [7:0]  sil, cm;
  int          err_total = 0;
  int          checks = 0;
  logic [15:0] got;
  logic        ok;
  logic [6:0]  idx_t [15] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09,
                             7'h10, 7'h11, 7'h12, 7'h13, 7'h0a, 7'h00};
  logic [7:0]  rst_t [15] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00,
                             8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  pat_t [15] = '{8'h81, 8'h80, 8'h00, 8'hc3, 8'hfe, 8'h5a, 8'h2a, 8'h15, 8'h3d,
                             8'h96, 8'h7f, 8'h02, 8'h01, 8'h5a, 8'h33};
  always #5 clk = ~clk;
  dac_attenuation_mute_ctrl #(.CYCLES_PER_SAMPLE(4)) dac_attenuation_mute_ctrl_i (.CLK(clk),
    .RST_N(rst_n), .CTRL_STB(stb), .CTRL_WORD(word), .RD_WORD(rdw), .RD_VALID(rdv),
    .ATTEN_APPLIED(lvl), .CH_SILENT(sil), .OUT_TO_COMMON_MODE(cm), .ROLLOFF_SLOW(roll),
    .CLKOUT_HALF(half), .CLKOUT_DISABLE(cdis), .AUDIO_FORMAT(fmt));
  ctrl_host ctrl_host_i (.clk(clk), .stb(stb), .word(word), .rdw(rdw), .rdv(rdv));
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] dat);
    ctrl_host_i.access(1'b0, idx, dat, got, ok);
  endtask
  task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
    ctrl_host_i.access(1'b1, idx, 8'h00, got, ok);
    check("read", {ok, got}, {2'b11, idx, exp});
  endtask
  // Waits a bounded time for a channel level, then compares it
  task automatic wlvl(input int ch, input logic [7:0] v);
    for (int n = 0; n < 5000 && lvl[ch*8 +: 8] !== v; n++) @(posedge clk);
    #1;
    check("level", lvl[ch*8 +: 8], v);
  endtask
  // Register defaults, write/read-back, derived outputs, then ramps
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 15; i++) rd_chk(idx_t[i], rst_t[i]);
    check("outs", {roll, half, cdis, fmt, cm}, 14'h0000);
    for (int i = 0; i < 15; i++) wr(idx_t[i], pat_t[i]);
    for (int i = 0; i < 15; i++) rd_chk(idx_t[i], i < 13 ? pat_t[i] : 8'h00);
    repeat (2) @(posedge clk);
    check("outs", {roll, half, cdis, fmt, cm}, 14'h3d55);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wr(7'h01, 8'h81);
    wlvl(0, 8'h81);
    check("silent", sil[0], 1'b0);
    wr(7'h03, 8'h10);
    wr(7'h12, 8'h02);
    wlvl(7, 8'h80);
    wlvl(2, 8'h80);
    check("silent", {sil[7], sil[2]}, 2'b11);
    wr(7'h12, 8'h00);
    wlvl(7, 8'hff);
    wr(7'h02, 8'hf0);
    wlvl(1, 8'hf8);
    wr(7'h02, 8'hfc);
    check("level", lvl[15:8], 8'hf8);
    wlvl(1, 8'hfc);
    end_of_test();
  end
  // Cuts a hang short
  initial begin
    #500000;
    err_total++;
    end_of_test();
  end
endmodule // dac_attenuation_mute_ctrl_test
